// ==== verilog/ssp_port.sv ====
// Serial peripheral port: register slave, shift engine and word buffers
//
// How it works
// - single slot standard, eight-word enhanced buffering
// - framed protocol, master or slave, four configurations
// - select pin or data out may go unused
// - select pin: low select, or frame pulse
// - master starts shifting once a word is written
// - enable bit turns module on, claims pins
// - idle stop bit halts module in idle
// - element count shows pending or unread words
// - shifter empty flag shows engine idle
// - overflow set on lost word, software clears
// - enhanced transmit interrupt conditions by mode code
// - enhanced receive interrupt conditions by mode code
// - standard transmit full set on write, cleared on load
// - enhanced transmit full while all slots used
// - standard receive full set on word, read clears
// - enhanced receive full while all slots unread
// - frame edge bit (master driving the pulse): coincide with or precede first bit
// - secondary divider from 1:1 to 8:1
// - primary divider 1, 4, 16 or 64
`timescale 1ns/1ps
module ssp_port (
  input wire logic ref_clk_i,               // Core clock, 200 MHz
  input wire logic rst_n_i,                 // Async reset, active low
  input wire logic [3:0] s_axi_awaddr_i,    // Write address
  input wire logic s_axi_awvalid_i,         // Write address valid
  output logic s_axi_awready_o,             // Write address ready
  input wire logic [31:0] s_axi_wdata_i,    // Write data
  input wire logic [3:0] s_axi_wstrb_i,     // Write byte strobes
  input wire logic s_axi_wvalid_i,          // Write data valid
  output logic s_axi_wready_o,              // Write data ready
  output logic [1:0] s_axi_bresp_o,         // Write response
  output logic s_axi_bvalid_o,              // Write response valid
  input wire logic s_axi_bready_i,          // Write response ready
  input wire logic [3:0] s_axi_araddr_i,    // Read address
  input wire logic s_axi_arvalid_i,         // Read address valid
  output logic s_axi_arready_o,             // Read address ready
  output logic [31:0] s_axi_rdata_o,        // Read data
  output logic [1:0] s_axi_rresp_o,         // Read response
  output logic s_axi_rvalid_o,              // Read data valid
  input wire logic s_axi_rready_i,          // Read data ready
  input wire logic idle_mode_i,             // Device in idle mode
  input wire logic shift_clock_pin_i,       // Shift clock pin level
  output logic shift_clock_pin_o,           // Shift clock drive
  output logic shift_clock_pin_oe_o,        // Shift clock enable
  input wire logic serial_in_pin_i,         // Serial data in
  output logic serial_out_pin_o,            // Serial data out
  output logic serial_out_pin_oe_o,         // Serial data out enable
  input wire logic select_or_frame_pin_i,   // Select or frame in
  output logic select_or_frame_pin_o,       // Frame pulse drive
  output logic select_or_frame_pin_oe_o,    // Frame pulse enable
  output logic port_irq_flag_o              // Buffer event condition
);
  typedef struct packed {
    logic [3:0] awaddr;
    logic aw_have;
    logic w_have;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    logic idle_stop;
    logic [2:0] buffer_irq_mode;
    logic rov;
    logic [15:0] con1;
    logic [15:0] con2;
    logic [2:0] s_sck;
    logic [2:0] s_sdi;
    logic [2:0] s_ss;
    logic f_sck;
    logic f_sdi;
    logic f_ss;
    logic act_prev;
    ssp_pkg::ssp_state_t state;
    logic phase;
    logic [ssp_pkg::HC_W-1:0] hc;
    logic [3:0] bitcnt;
    logic [15:0] sr;
    logic smp_bit;
    logic out_bit;
    logic sck_q;
    logic fs_q;
    logic irq;
  } ssp_core_t;

  ssp_core_t r_reg, r_next;

  logic master, cke, ckp, input_sample_phase_bit, select_pin_enable_bit, w16, fr_en, fr_in, fpol, fe, ben;
  logic halt, samp_lead, sck_active, ss_act, sync_act, tick, start;
  logic [3:0] msb, lim;
  logic [6:0] prim;
  logic [3:0] sec;
  logic [ssp_pkg::HC_W-1:0] half_m1;
  logic tx_push, tx_pop, tx_ready, tx_valid, rx_push, rx_pop, rx_ready;
  logic rx_valid;
  logic [15:0] tx_head, rx_head, rx_word, ld_word, nsr, stat_rd, wbmask;
  logic [3:0] tx_cnt, rx_cnt;
  logic [2:0] bec;
  logic lead, trail, ev_load, ev_done, rov_set, rov_clr, fs_act, cond;

  // Configuration fields
  assign master = r_reg.con1[ssp_pkg::B_MASTER_ROLE_BIT];
  assign cke = r_reg.con1[ssp_pkg::B_CKE];
  assign ckp = r_reg.con1[ssp_pkg::B_CKP];
  assign input_sample_phase_bit = r_reg.con1[ssp_pkg::B_SMP];
  assign select_pin_enable_bit = r_reg.con1[ssp_pkg::B_SELECT_PIN_ENABLE_BIT];
  assign w16 = r_reg.con1[ssp_pkg::B_WORD16];
  assign fr_en = r_reg.con2[ssp_pkg::B_FRMEN];
  assign fr_in = r_reg.con2[ssp_pkg::B_FSD];
  assign fpol = r_reg.con2[ssp_pkg::B_FPOL];
  assign fe = r_reg.con2[ssp_pkg::B_FE];
  assign ben = r_reg.con2[ssp_pkg::B_BEN];
  assign msb = w16 ? ssp_pkg::MSB16 : ssp_pkg::MSB8;
  assign lim = ben ? ssp_pkg::LIM_ENH : ssp_pkg::LIM_STD;
  assign halt = idle_mode_i & r_reg.idle_stop;
  // Slave sampling follows the clock edge only; sample phase is master-only
  assign samp_lead = cke & ~(master & input_sample_phase_bit);

  // Bit clock divider, half period counted in core cycles
  always_comb begin
    unique case (r_reg.con1[ssp_pkg::B_PRIMARY_CLOCK_DIVIDER_LO +: 2])
      2'h3: prim = 7'h01;
      2'h2: prim = 7'h04;
      2'h1: prim = 7'h10;
      2'h0: prim = 7'h40;
    endcase
  end
  assign sec = 4'h8 - {1'b0, r_reg.con1[ssp_pkg::B_SECONDARY_CLOCK_DIVIDER_LO +: 3]};
  assign half_m1 = ssp_pkg::HC_W'(ssp_pkg::HC_W'(prim) * ssp_pkg::HC_W'(sec)
                   - 1'b1);
  assign tick = (r_reg.hc == half_m1);

  // Filtered pin levels
  assign sck_active = (r_reg.f_sck != ckp);
  assign ss_act = ~r_reg.f_ss;
  assign sync_act = (r_reg.f_ss == fpol);
  assign start = master ? tx_valid
               : (fr_en ? (~fr_in | sync_act) : (~select_pin_enable_bit | ss_act));
  assign ld_word = tx_valid ? tx_head : 16'h0000;
  assign wbmask = {{8{r_reg.wstrb[1]}}, {8{r_reg.wstrb[0]}}};
  assign bec = (master ? tx_cnt : rx_cnt) > 4'h7 ? 3'h7
             : (master ? tx_cnt[2:0] : rx_cnt[2:0]);

  // Status word as software sees it
  assign stat_rd = {r_reg.en, 1'b0, r_reg.idle_stop, 2'b00, bec,
                    (r_reg.state == ssp_pkg::ST_IDLE),
                    r_reg.rov, ~rx_valid, r_reg.buffer_irq_mode,
                    ~tx_ready, ~rx_ready};

  // Transmit words waiting for the shifter
  ssp_fifo #(.W(16), .DEPTH(ssp_pkg::FIFO_DEPTH), .CW(ssp_pkg::CNT_W)) u_tx (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(~r_reg.en),
    .limit_i(lim),
    .push_valid_i(tx_push),
    .push_ready_o(tx_ready),
    .push_data_i(r_reg.wdata),
    .pop_valid_o(tx_valid),
    .pop_ready_i(tx_pop),
    .pop_data_o(tx_head),
    .count_o(tx_cnt)
  );

  // Received words waiting for software
  ssp_fifo #(.W(16), .DEPTH(ssp_pkg::FIFO_DEPTH), .CW(ssp_pkg::CNT_W)) u_rx (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(~r_reg.en),
    .limit_i(lim),
    .push_valid_i(rx_push),
    .push_ready_o(rx_ready),
    .push_data_i(rx_word),
    .pop_valid_o(rx_valid),
    .pop_ready_i(rx_pop),
    .pop_data_o(rx_head),
    .count_o(rx_cnt)
  );

  // Next state of the whole port
  always_comb begin
    r_next = r_reg;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_word = 16'h0000;
    nsr = 16'h0000;
    lead = 1'b0;
    trail = 1'b0;
    ev_load = 1'b0;
    ev_done = 1'b0;
    rov_set = 1'b0;
    rov_clr = 1'b0;
    fs_act = 1'b0;
    cond = 1'b0;

    // Three-stage pin synchronisers, level accepted when the last two stages agree
    r_next.s_sck = {r_reg.s_sck[1:0], shift_clock_pin_i};
    r_next.s_sdi = {r_reg.s_sdi[1:0], serial_in_pin_i};
    r_next.s_ss = {r_reg.s_ss[1:0], select_or_frame_pin_i};
    if (r_reg.s_sck[1] == r_reg.s_sck[2]) r_next.f_sck = r_reg.s_sck[2];
    if (r_reg.s_sdi[1] == r_reg.s_sdi[2]) r_next.f_sdi = r_reg.s_sdi[2];
    if (r_reg.s_ss[1] == r_reg.s_ss[2]) r_next.f_ss = r_reg.s_ss[2];
    r_next.act_prev = sck_active;

    // Write address and data are taken independently
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      r_next.aw_have = 1'b1;
      r_next.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      r_next.w_have = 1'b1;
      r_next.wdata = s_axi_wdata_i[15:0];
      r_next.wstrb = s_axi_wstrb_i[1:0];
    end
    if (r_reg.bvalid && s_axi_bready_i) r_next.bvalid = 1'b0;
    if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = ssp_pkg::RESP_OKAY;
      unique case (r_reg.awaddr)
        ssp_pkg::OFF_BUF: begin
          // Writes while disabled or full are dropped
          tx_push = r_reg.en & (|r_reg.wstrb);
        end
        ssp_pkg::OFF_STAT: begin
          if (r_reg.wstrb[1]) begin
            r_next.en = r_reg.wdata[ssp_pkg::B_EN];
            r_next.idle_stop = r_reg.wdata[ssp_pkg::B_IDLE_STOP];
          end
          if (r_reg.wstrb[0]) begin
            r_next.buffer_irq_mode = r_reg.wdata[ssp_pkg::B_BUFFER_IRQ_MODE_LO +: 3];
            rov_clr = ~r_reg.wdata[ssp_pkg::B_ROV];
          end
        end
        ssp_pkg::OFF_CON1: begin
          r_next.con1 = ((r_reg.con1 & ~wbmask) | (r_reg.wdata & wbmask))
                        & ssp_pkg::CON1_MASK;
        end
        ssp_pkg::OFF_CON2: begin
          r_next.con2 = ((r_reg.con2 & ~wbmask) | (r_reg.wdata & wbmask))
                        & ssp_pkg::CON2_MASK;
        end
        default: r_next.bresp = ssp_pkg::RESP_SLVERR;
      endcase
    end

    // Read answered on the same edge that takes the address
    if (r_reg.rvalid && s_axi_rready_i) r_next.rvalid = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = ssp_pkg::RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        ssp_pkg::OFF_BUF: begin
          r_next.rdata = {16'h0000, rx_valid ? rx_head : 16'h0000};
          rx_pop = rx_valid;
        end
        ssp_pkg::OFF_STAT: r_next.rdata = {16'h0000, stat_rd};
        ssp_pkg::OFF_CON1: r_next.rdata = {16'h0000, r_reg.con1};
        ssp_pkg::OFF_CON2: r_next.rdata = {16'h0000, r_reg.con2};
        default: r_next.rresp = ssp_pkg::RESP_SLVERR;
      endcase
    end

    // Shift engine; halted in idle mode it simply freezes mid-word
    if (!r_reg.en) begin
      r_next.state = ssp_pkg::ST_IDLE;
      r_next.phase = 1'b0;
      r_next.hc = '0;
    end else if (!halt) begin
      unique case (r_reg.state)
        ssp_pkg::ST_IDLE: begin
          if (start) begin
            r_next.sr = ld_word;
            r_next.out_bit = ld_word[msb];
            tx_pop = tx_valid;
            ev_load = tx_valid;
            r_next.bitcnt = 4'h0;
            r_next.phase = 1'b0;
            r_next.hc = '0;
            r_next.state = (master && fr_en && (fr_in || !fe))
                         ? ssp_pkg::ST_SYNC : ssp_pkg::ST_BITS;
          end
        end
        ssp_pkg::ST_SYNC: begin
          // Master waits for an outside pulse or sends one bit time early
          if (fr_in) begin
            if (sync_act) r_next.state = ssp_pkg::ST_BITS;
          end else if (tick) begin
            r_next.hc = '0;
            r_next.phase = ~r_reg.phase;
            if (r_reg.phase) r_next.state = ssp_pkg::ST_BITS;
          end else begin
            r_next.hc = ssp_pkg::HC_W'(r_reg.hc + 1'b1);
          end
        end
        ssp_pkg::ST_BITS: begin
          if (master) begin
            if (tick) begin
              r_next.hc = '0;
              r_next.phase = ~r_reg.phase;
              lead = ~r_reg.phase;
              trail = r_reg.phase;
            end else begin
              r_next.hc = ssp_pkg::HC_W'(r_reg.hc + 1'b1);
            end
          end else begin
            lead = sck_active & ~r_reg.act_prev;
            trail = ~sck_active & r_reg.act_prev;
          end
          if (lead) begin
            if (!cke) r_next.out_bit = r_reg.sr[msb];
            if (samp_lead) r_next.smp_bit = r_reg.f_sdi;
          end
          if (trail) begin
            nsr = {r_reg.sr[14:0], samp_lead ? r_reg.smp_bit : r_reg.f_sdi};
            r_next.sr = nsr;
            r_next.bitcnt = 4'(r_reg.bitcnt + 1'b1);
            if (cke) r_next.out_bit = nsr[msb];
            if (r_reg.bitcnt == msb) begin
              ev_done = 1'b1;
              r_next.state = ssp_pkg::ST_IDLE;
              rx_word = w16 ? nsr : {8'h00, nsr[7:0]};
              rx_push = rx_ready;
              rov_set = ~rx_ready;
            end
          end
          // Select released mid-word abandons the word
          if (!master && !fr_en && select_pin_enable_bit && !ss_act) begin
            r_next.state = ssp_pkg::ST_IDLE;
          end
        end
        default: r_next.state = ssp_pkg::ST_IDLE;
      endcase
    end

    // Hardware set wins over a software clear
    r_next.rov = (r_reg.rov & ~rov_clr) | rov_set;

    // Pin drive levels registered from the next state
    fs_act = fr_en & ~fr_in & ((r_next.state == ssp_pkg::ST_SYNC)
           | ((r_next.state == ssp_pkg::ST_BITS) && (r_next.bitcnt == 4'h0)
              && (fe || !master)));
    r_next.fs_q = fpol ? fs_act : ~fs_act;
    r_next.sck_q = ckp ^ (master & r_next.phase
                   & (r_next.state == ssp_pkg::ST_BITS));

    // Buffer event condition: each finished word in standard mode, by mode code in enhanced
    if (!ben) begin
      cond = ev_done;
    end else begin
      unique case (r_reg.buffer_irq_mode)
        3'h7: cond = ~tx_ready;
        3'h6: cond = ev_load & (tx_cnt == 4'h1);
        3'h5: cond = ev_done & ~tx_valid;
        3'h4: cond = ev_load;
        3'h3: cond = ~rx_ready;
        3'h2: cond = (rx_cnt >= ssp_pkg::RX_3Q);
        3'h1: cond = rx_valid;
        3'h0: cond = rx_pop & (rx_cnt == 4'h1);
      endcase
    end
    r_next.irq = r_reg.en & cond;
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Bus handshakes; one write and one read in flight
  assign s_axi_awready_o = ~r_reg.aw_have & ~r_reg.bvalid;
  assign s_axi_wready_o = ~r_reg.w_have & ~r_reg.bvalid;
  assign s_axi_bvalid_o = r_reg.bvalid;
  assign s_axi_bresp_o = r_reg.bresp;
  assign s_axi_arready_o = ~r_reg.rvalid;
  assign s_axi_rvalid_o = r_reg.rvalid;
  assign s_axi_rdata_o = r_reg.rdata;
  assign s_axi_rresp_o = r_reg.rresp;

  // Pins claimed only while enabled
  assign shift_clock_pin_o = r_reg.sck_q;
  assign shift_clock_pin_oe_o = r_reg.en & master
                                & ~r_reg.con1[ssp_pkg::B_DISSCK];
  assign serial_out_pin_o = r_reg.out_bit;
  assign serial_out_pin_oe_o = r_reg.en & ~r_reg.con1[ssp_pkg::B_DISSDO]
                               & (master | ~select_pin_enable_bit | ss_act);
  assign select_or_frame_pin_o = r_reg.fs_q;
  assign select_or_frame_pin_oe_o = r_reg.en & fr_en & ~fr_in;
  assign port_irq_flag_o = r_reg.irq;
endmodule

// ==== include/ssp_pkg.sv ====
// Constants, field positions and types shared by the serial port files
package ssp_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] OFF_BUF = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_CON1 = 4'h8;
  localparam logic [3:0] OFF_CON2 = 4'hC;

  // Status/control field positions
  localparam int B_EN = 15;
  localparam int B_IDLE_STOP = 13;
  localparam int B_ROV = 6;
  localparam int B_BUFFER_IRQ_MODE_LO = 2;

  // Control one field positions
  localparam int B_DISSCK = 12;
  localparam int B_DISSDO = 11;
  localparam int B_WORD16 = 10;
  localparam int B_SMP = 9;
  localparam int B_CKE = 8;
  localparam int B_SELECT_PIN_ENABLE_BIT = 7;
  localparam int B_CKP = 6;
  localparam int B_MASTER_ROLE_BIT = 5;
  localparam int B_SECONDARY_CLOCK_DIVIDER_LO = 2;
  localparam int B_PRIMARY_CLOCK_DIVIDER_LO = 0;

  // Control two field positions
  localparam int B_FRMEN = 15;
  localparam int B_FSD = 14;
  localparam int B_FPOL = 13;
  localparam int B_FE = 1;
  localparam int B_BEN = 0;

  // Writable bits and reset values
  localparam logic [15:0] CON1_MASK = 16'h1FFF;
  localparam logic [15:0] CON2_MASK = 16'hE003;
  localparam logic [15:0] CON1_RST = 16'h0000;
  localparam logic [15:0] CON2_RST = 16'h0000;

  // Buffer sizing and counts
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam logic [3:0] LIM_STD = 4'h1;
  localparam logic [3:0] LIM_ENH = 4'h8;
  localparam logic [3:0] RX_3Q = 4'h6;
  localparam logic [3:0] MSB8 = 4'h7;
  localparam logic [3:0] MSB16 = 4'hF;
  localparam int HC_W = 10;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_BITS} ssp_state_t;
endpackage

// ==== verilog/ssp_fifo.sv ====
// Word buffer with programmable fill limit, used for transmit and receive
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8,
  parameter int CW = 4
) (
  input wire logic clk_i,                // Core clock
  input wire logic rst_n_i,              // Async reset, active low
  input wire logic flush_i,              // Empties the buffer
  input wire logic [CW-1:0] limit_i,     // Words counted as full
  input wire logic push_valid_i,         // Offer a word
  output logic push_ready_o,             // Room below the limit
  input wire logic [W-1:0] push_data_i,  // Word to store
  output logic pop_valid_o,              // A word is held
  input wire logic pop_ready_i,          // Take the head word
  output logic [W-1:0] pop_data_o,       // Head word
  output logic [CW-1:0] count_o          // Words held
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } ssp_fifo_state_t;

  ssp_fifo_state_t r_reg, r_next;
  logic push, pop;

  // Full is against the limit so standard mode behaves as a single slot
  assign push_ready_o = (r_reg.cnt < limit_i);
  assign pop_valid_o = (r_reg.cnt != '0);
  assign pop_data_o = r_reg.mem[r_reg.rp];
  assign count_o = r_reg.cnt;
  assign push = push_valid_i & push_ready_o;
  assign pop = pop_ready_i & pop_valid_o;

  // Pointer and count update
  always_comb begin
    r_next = r_reg;
    if (flush_i) begin
      r_next.wp = '0;
      r_next.rp = '0;
      r_next.cnt = '0;
    end else begin
      if (push) begin
        r_next.mem[r_reg.wp] = push_data_i;
        r_next.wp = AW'(r_reg.wp + 1'b1);
      end
      if (pop) begin
        r_next.rp = AW'(r_reg.rp + 1'b1);
      end
      r_next.cnt = CW'(r_reg.cnt + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// ==== tb/ssp_peer.sv ====
// Far-side serial device model
`timescale 1ns/1ps
module ssp_peer #(
  parameter logic [7:0] FIRST = 8'h3C // First word sent back
) (
  input wire logic sck_i, // Shift clock
  input wire logic sdo_i, // Data from port
  output logic sdi_o, // Data to port
  output logic [7:0] got_o // Last word taken
);
  logic [7:0] tx_reg, rx_reg, nxt;
  logic [2:0] cnt;
  logic live;
  initial begin
    tx_reg = FIRST;
    nxt = FIRST + 8'h01;
    cnt = 3'h0;
    live = 1'b0;
  end
  assign sdi_o = tx_reg[7];
  // Sample on rising clock, MSB first
  always @(posedge sck_i) begin
    live <= 1'b1;
    rx_reg <= {rx_reg[6:0], sdo_i};
    cnt <= cnt + 3'h1;
    if (cnt == 3'h7) got_o <= {rx_reg[6:0], sdo_i};
  end
  // Shift on falling clock; live guards the time-zero edge
  always @(negedge sck_i) begin
    if (live && cnt == 3'h0) begin
      tx_reg <= nxt;
      nxt <= nxt + 8'h01;
    end else if (live) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end
endmodule

// ==== tb/ssp_port_assertions.sv ====
// Bus and pin checks bound to the serial port
`timescale 1ns/1ps
module ssp_port_chk (
  input wire logic ref_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [3:0] s_axi_awaddr_i, // AW addr
  input wire logic s_axi_awvalid_i, // AW valid
  input wire logic s_axi_awready_o, // AW ready
  input wire logic [31:0] s_axi_wdata_i, // W data
  input wire logic s_axi_wvalid_i, // W valid
  input wire logic s_axi_wready_o, // W ready
  input wire logic [1:0] s_axi_bresp_o, // B resp
  input wire logic s_axi_bvalid_o, // B valid
  input wire logic [3:0] s_axi_araddr_i, // AR addr
  input wire logic s_axi_arvalid_i, // AR valid
  input wire logic s_axi_arready_o, // AR ready
  input wire logic [31:0] s_axi_rdata_o, // R data
  input wire logic [1:0] s_axi_rresp_o, // R resp
  input wire logic s_axi_rvalid_o, // R valid
  input wire logic shift_clock_pin_oe_o, // Clock enable
  input wire logic serial_out_pin_oe_o, // Data enable
  input wire logic select_or_frame_pin_oe_o // Frame enable
);
  logic wr_go, rd_go, en_reg, en_d;
  // Handshakes on the bus
  assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o;
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  // Enable shadow; only joint address and data writes are tracked
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_reg <= 1'b0;
      en_d <= 1'b0;
    end else begin
      en_d <= en_reg;
      if (wr_go && s_axi_awaddr_i == ssp_pkg::OFF_STAT)
        en_reg <= s_axi_wdata_i[ssp_pkg::B_EN];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_aw_blocked: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("Write taken with response pending");
  a_b_follows: assert property (wr_go |-> ##2 s_axi_bvalid_o)
    else $error("Write response late");
  a_wr_bad: assert property (
    wr_go && s_axi_awaddr_i[1:0] != 2'h0 |-> ##2
    s_axi_bresp_o == ssp_pkg::RESP_SLVERR) else $error("Bad write ok");
  a_wr_good: assert property (
    wr_go && s_axi_awaddr_i[1:0] == 2'h0 |-> ##2
    s_axi_bresp_o == ssp_pkg::RESP_OKAY) else $error("Good write err");
  a_r_follows: assert property (rd_go |=> s_axi_rvalid_o)
    else $error("Read data late");
  a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("Read taken with data pending");
  a_rd_bad: assert property (
    rd_go && s_axi_araddr_i[1:0] != 2'h0 |=> s_axi_rdata_o == 32'h0
    && s_axi_rresp_o == ssp_pkg::RESP_SLVERR) else $error("Bad read ok");
  a_rdata_upper: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("Read data upper half set");
  a_off_quiet: assert property (
    !en_reg && !en_d |=> !shift_clock_pin_oe_o && !serial_out_pin_oe_o
    && !select_or_frame_pin_oe_o) else $error("Pins driven while off");
  c_bad_write: cover property (wr_go && s_axi_awaddr_i[1:0] != 2'h0);
  c_read: cover property (rd_go);
  c_driving: cover property (shift_clock_pin_oe_o);
endmodule

bind ssp_port ssp_port_chk i_ssp_port_chk (.*);

// ==== tb/ssp_port_tb.sv ====
// Self-checking bench for the serial port
`timescale 1ns/1ps
module ssp_port_tb;
  localparam logic [3:0] A_BUF = ssp_pkg::OFF_BUF;
  localparam logic [3:0] A_STAT = ssp_pkg::OFF_STAT;
  logic ref_clk, rst_n, awv, wv, bready, arv, rready;
  logic awready, wready, bvalid, arready, rvalid, sck, sdo, sdi, irq;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r;
  logic [15:0] d;
  logic [7:0] got;
  int n_errors, compares;
  // Core clock, 5 ns period
  always #2.5 ref_clk = ~ref_clk;
  ssp_port i_ssp_port (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .idle_mode_i(1'b0),
    .shift_clock_pin_i(1'b0), .shift_clock_pin_o(sck),
    .shift_clock_pin_oe_o(), .serial_in_pin_i(sdi),
    .serial_out_pin_o(sdo), .serial_out_pin_oe_o(),
    .select_or_frame_pin_i(1'b1), .select_or_frame_pin_o(),
    .select_or_frame_pin_oe_o(), .port_irq_flag_o(irq)
  );
  ssp_peer i_ssp_peer (.sck_i(sck), .sdo_i(sdo), .sdi_o(sdi),
    .got_o(got));
  task automatic chk(input string s, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic results();
    $display("Compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bad();
    n_errors++;
    $display("Wait ran out");
    results();
  endtask
  // Bus write; handshakes judged on values settled at the falling edge,
  // so the rising edge that follows is the one that moves the item
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    int n;
    logic a_ok, w_ok, b_ok;
    awaddr <= a;
    wdata <= {16'h0000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    n = 0;
    b_ok = 1'b0;
    while (!b_ok && n < 100) begin
      @(negedge ref_clk);
      a_ok = awv & awready;
      w_ok = wv & wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge ref_clk);
      n++;
      if (a_ok) awv <= 1'b0;
      if (w_ok) wv <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_ok) bad();
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    int n;
    logic a_ok, r_ok;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    n = 0;
    r_ok = 1'b0;
    while (!r_ok && n < 100) begin
      @(negedge ref_clk);
      a_ok = arv & arready;
      r_ok = rvalid;
      d = rdata[15:0];
      r = rresp;
      @(posedge ref_clk);
      n++;
      if (a_ok) arv <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_ok) bad();
    @(posedge ref_clk);
  endtask
  // Poll one status bit until it reaches a value
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(A_STAT);
      n++;
    end while (d[b] !== v && n < 3000);
    if (d[b] !== v) bad();
  endtask
  // Main sequence: reset, standard master, enhanced master
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {awv, wv, bready, arv, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(A_STAT);
    chk("stat_reset", d, 16'h00A0);
    wr(4'h2, 16'h0000);
    chk("wr_bad_resp", 16'(r), 16'(ssp_pkg::RESP_SLVERR));
    rd(4'h6);
    chk("rd_bad_data", d, 16'h0000);
    $display("Test reset and bus done");
    wr(ssp_pkg::OFF_CON1, 16'h013A);
    wr(A_STAT, 16'h0000);
    wr(A_STAT, 16'h8000);
    wr(A_BUF, 16'h00A5);
    poll(0, 1'b1);
    chk("peer_word", {8'h00, got}, 16'h00A5);
    rd(A_BUF);
    chk("rx_word", d, 16'h003C);
    rd(A_STAT);
    chk("rx_full_clr", 16'(d[0]), 16'h0000);
    wr(A_BUF, 16'h005A);
    poll(0, 1'b1);
    wr(A_BUF, 16'h000F);
    poll(6, 1'b1);
    rd(A_BUF);
    chk("kept_word", d, 16'h003D);
    wr(A_STAT, 16'h8000);
    rd(A_STAT);
    chk("ovf_clr", 16'(d[6]), 16'h0000);
    $display("Test standard done");
    wr(A_STAT, 16'h0000);
    wr(ssp_pkg::OFF_CON1, 16'h013D);
    wr(ssp_pkg::OFF_CON2, 16'h0001);
    wr(A_STAT, 16'h800C);
    for (int i = 0; i < 9; i++) wr(A_BUF, 16'(16'h0010 + i));
    rd(A_STAT);
    chk("pending", 16'(d[10:8]), 16'h0007);
    chk("shifter_busy", 16'(d[7]), 16'h0000);
    chk("tx_full", 16'(d[1]), 16'h0001);
    poll(6, 1'b1);
    rd(A_STAT);
    chk("rx_full", 16'(d[0]), 16'h0001);
    chk("shifter_idle", 16'(d[7]), 16'h0001);
    chk("irq_rx_full", 16'(irq), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      rd(A_BUF);
      chk("fifo_word", d, 16'(16'h003F + i));
    end
    rd(A_STAT);
    chk("rx_drained", 16'({d[5], d[0]}), 16'h0002);
    chk("peer_last", {8'h00, got}, 16'h0018);
    chk("irq_off", 16'(irq), 16'h0000);
    $display("Test enhanced done");
    results();
  end
endmodule
